// File: hdl/scs_defines.vh
// Constants for the system clock source control block.
// Assumes a 100 MHz system clock and a 32-bit APB register bus.
`ifndef SCS_DEFINES_VH
`define SCS_DEFINES_VH

`define SCS_CLK_PERIOD_NS     10
// Longest gap between slow RC edges before it is called stopped
`define SCS_SLOW_RC_TIMEOUT_NS 100000
`define SCS_SLOW_RC_TIMEOUT_CYC (`SCS_SLOW_RC_TIMEOUT_NS / `SCS_CLK_PERIOD_NS)

// Register byte offsets
`define SCS_ADDR_CTRL         12'h000
`define SCS_ADDR_STATUS       12'h004
`define SCS_ADDR_SLOW_SEL     12'h008
`define SCS_ADDR_HS_TRIM      12'h00C
`define SCS_ADDR_SLOW_CAL     12'h010

// CTRL fields
`define SCS_CTRL_MODE_LSB     0
`define SCS_CTRL_MODE_MSB     1
`define SCS_CTRL_TRIG_BIT     2
`define SCS_CTRL_DIV_LSB      3
`define SCS_CTRL_DIV_MSB      5

// High-speed modes after wake
`define SCS_MODE_STAY_RC      2'h0
`define SCS_MODE_AUTO         2'h1
`define SCS_MODE_SOFTWARE     2'h2

// Slow clock sources
`define SCS_SLOW_RC           2'h0
`define SCS_SLOW_XTAL         2'h1
`define SCS_SLOW_EXT          2'h2

// Processor divider: 0 = undivided .. 5 = divide by 32
`define SCS_DIV_MAX           3'h5

// Reset values
`define SCS_RST_MODE          2'h0
`define SCS_RST_DIV           3'h0
`define SCS_RST_HS_TRIM       8'h00
`define SCS_RST_SLOW_CAL      16'h0000

`endif

// File: hdl/scs_pin_sync.v
// Three-stage synchroniser for an input from outside the clock domain.
// Assumes the input is slower than a quarter of the system clock.
`timescale 1ns/1ps
`default_nettype none

module scs_pin_sync (
    input  wire clk,
    input  wire reset_n,
    input  wire ce,
    input  wire pin,
    output reg  level,
    output reg  rise
);

    reg s1;
    reg s2;
    reg s3;

    ////////////////////////////////////////////////////////////////////////
    // Change accepted only once the second and third stages agree
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s1    <= 1'b0;
            s2    <= 1'b0;
            s3    <= 1'b0;
            level <= 1'b0;
            rise  <= 1'b0;
        end else if (ce) begin
            s1   <= pin;
            s2   <= s1;
            s3   <= s2;
            rise <= 1'b0;
            if (s2 == s3) begin
                level <= s3;
                rise  <= s3 & ~level;
            end
        end
    end

endmodule // scs_pin_sync

`default_nettype wire

// File: hdl/scs_clock_control.v
// System clock source control: high-speed source switch, dividers and
// slow clock source selection, with an APB register slave.
// Assumes oscillator outputs arrive as asynchronous pins and that the
// power controller drives SLEEP synchronously to CLK.
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "scs_defines.vh"

module scs_clock_control #(
    parameter SLOW_RC_TIMEOUT = `SCS_SLOW_RC_TIMEOUT_CYC
) (
    input  wire        CLK,
    input  wire        RESET_N,
    input  wire        CE,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output reg         PREADY,
    output reg         PSLVERR,
    input  wire        SLEEP,
    input  wire        HS_RC_OSC,
    input  wire        HS_XTAL_OSC,
    input  wire        HS_XTAL_READY,
    input  wire        SLOW_RC_OSC,
    input  wire        SLOW_XTAL_OSC,
    input  wire        GENERAL_IO_NINE,
    output reg         HS_RC_EN,
    output reg         HS_XTAL_EN,
    output reg  [7:0]  HS_RC_TRIM,
    output reg         SLOW_XTAL_EN,
    output reg  [15:0] SLOW_CAL,
    output reg         RADIO_CLK_EN,
    output reg         PERIPH_CLK_EN,
    output reg         CPU_CLK_EN,
    output reg         SLOW_CLK_EN,
    output reg         HS_ON_XTAL
);

    localparam ST_RC   = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_XTAL = 2'h2;

    // Mask of low tick-counter bits that must all be set for a divided tick
    function [4:0] div_mask;
        input [2:0] d;
        begin
            div_mask = 5'h1F >> (3'h5 - ((d > `SCS_DIV_MAX) ? `SCS_DIV_MAX : d));
        end
    endfunction

    wire        rc_rise;
    wire        xt_rise;
    wire        xt_ready;
    wire        srcx_rise;
    wire        sxt_rise;
    wire        ext_rise;

    reg  [1:0]  hs_mode;
    reg  [2:0]  cpu_div;
    reg  [2:0]  act_div;
    reg         sw_trig;
    reg  [1:0]  slow_sel;
    reg         slow_locked;
    reg  [1:0]  state;
    reg  [4:0]  tick_cnt;
    reg         sleep_q;
    reg  [13:0] rc_gap;
    reg         slow_rc_run;
    reg  [31:0] rd_word;
    reg         rd_hit;
    reg         hs_tick;
    reg         slow_tick;

    wire        wr_acc = PSEL & PENABLE & PWRITE & PREADY;
    wire        wake   = sleep_q & ~SLEEP;
    wire        wrap   = hs_tick & (tick_cnt == 5'h1F);

    ////////////////////////////////////////////////////////////////////////
    // Oscillator and pin inputs
    scs_pin_sync u_hs_rc (
        .clk(CLK), .reset_n(RESET_N), .ce(CE), .pin(HS_RC_OSC),
        .level(), .rise(rc_rise)
    );
    scs_pin_sync u_hs_xt (
        .clk(CLK), .reset_n(RESET_N), .ce(CE), .pin(HS_XTAL_OSC),
        .level(), .rise(xt_rise)
    );
    scs_pin_sync u_xt_rdy (
        .clk(CLK), .reset_n(RESET_N), .ce(CE), .pin(HS_XTAL_READY),
        .level(xt_ready), .rise()
    );
    scs_pin_sync u_slow_rc (
        .clk(CLK), .reset_n(RESET_N), .ce(CE), .pin(SLOW_RC_OSC),
        .level(), .rise(srcx_rise)
    );
    scs_pin_sync u_slow_xt (
        .clk(CLK), .reset_n(RESET_N), .ce(CE), .pin(SLOW_XTAL_OSC),
        .level(), .rise(sxt_rise)
    );
    scs_pin_sync u_slow_ext (
        .clk(CLK), .reset_n(RESET_N), .ce(CE), .pin(GENERAL_IO_NINE),
        .level(), .rise(ext_rise)
    );

    ////////////////////////////////////////////////////////////////////////
    // Selected high-speed and slow ticks
    always @* begin
        hs_tick = ~SLEEP & ((state == ST_XTAL) ? xt_rise : rc_rise);
        case (slow_sel)
            `SCS_SLOW_XTAL: slow_tick = sxt_rise;
            `SCS_SLOW_EXT:  slow_tick = ext_rise;
            default:        slow_tick = srcx_rise;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read decode
    always @* begin
        rd_word = 32'h00000000;
        rd_hit  = 1'b1;
        case (PADDR)
            `SCS_ADDR_CTRL: begin
                rd_word[`SCS_CTRL_MODE_MSB:`SCS_CTRL_MODE_LSB] = hs_mode;
                rd_word[`SCS_CTRL_TRIG_BIT] = sw_trig;
                rd_word[`SCS_CTRL_DIV_MSB:`SCS_CTRL_DIV_LSB]  = cpu_div;
            end
            `SCS_ADDR_STATUS: begin
                rd_word[0]   = HS_ON_XTAL;
                rd_word[1]   = xt_ready;
                rd_word[2]   = slow_rc_run;
                rd_word[3]   = slow_locked;
                rd_word[5:4] = slow_sel;
                rd_word[7:6] = state;
            end
            `SCS_ADDR_SLOW_SEL: rd_word[1:0]  = slow_sel;
            `SCS_ADDR_HS_TRIM:  rd_word[7:0]  = HS_RC_TRIM;
            `SCS_ADDR_SLOW_CAL: rd_word[15:0] = SLOW_CAL;
            default:            rd_hit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, answer registered
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            PRDATA  <= 32'h00000000;
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end else if (CE) begin
            if (PSEL & PENABLE & ~PREADY) begin
                PREADY  <= 1'b1;
                PSLVERR <= ~rd_hit;
                PRDATA  <= PWRITE ? 32'h00000000 : rd_word;
            end else begin
                PREADY  <= 1'b0;
                PSLVERR <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software-written configuration
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            hs_mode     <= `SCS_RST_MODE;
            cpu_div     <= `SCS_RST_DIV;
            sw_trig     <= 1'b0;
            slow_sel    <= `SCS_SLOW_RC;
            slow_locked <= 1'b0;
            HS_RC_TRIM  <= `SCS_RST_HS_TRIM;
            SLOW_CAL    <= `SCS_RST_SLOW_CAL;
        end else if (CE) begin
            // Trigger only lives while a switch is awaited
            if (state != ST_WAIT || hs_mode != `SCS_MODE_SOFTWARE)
                sw_trig <= 1'b0;
            if (wr_acc) begin
                case (PADDR)
                    `SCS_ADDR_CTRL: begin
                        hs_mode <= PWDATA[`SCS_CTRL_MODE_MSB:`SCS_CTRL_MODE_LSB];
                        cpu_div <= PWDATA[`SCS_CTRL_DIV_MSB:`SCS_CTRL_DIV_LSB];
                        if (PWDATA[`SCS_CTRL_TRIG_BIT])
                            sw_trig <= 1'b1;
                    end
                    `SCS_ADDR_SLOW_SEL: begin
                        // Reserved code 3 is ignored; a chosen source sticks
                        if (!slow_locked && PWDATA[1:0] != 2'h3 &&
                            PWDATA[1:0] != `SCS_SLOW_RC) begin
                            slow_sel    <= PWDATA[1:0];
                            slow_locked <= 1'b1;
                        end
                    end
                    // Trim survives divider changes, sleep and RC disable
                    `SCS_ADDR_HS_TRIM:  HS_RC_TRIM <= PWDATA[7:0];
                    `SCS_ADDR_SLOW_CAL: SLOW_CAL   <= PWDATA[15:0];
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // High-speed source switch
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state   <= ST_RC;
            sleep_q <= 1'b0;
        end else if (CE) begin
            sleep_q <= SLEEP;
            if (SLEEP) begin
                state <= ST_RC;
            end else begin
                case (state)
                    ST_RC: begin
                        if (wake || hs_mode != `SCS_MODE_STAY_RC)
                            state <= (hs_mode == `SCS_MODE_STAY_RC) ? ST_RC : ST_WAIT;
                    end
                    ST_WAIT: begin
                        // Move to ST_XTAL only at a counter wrap so no tick is cut short
                        if (hs_mode == `SCS_MODE_STAY_RC)
                            state <= ST_RC;
                        else if (xt_ready && wrap &&
                                 (hs_mode == `SCS_MODE_AUTO || sw_trig))
                            state <= ST_XTAL;
                    end
                    ST_XTAL: begin
                        if (!xt_ready && wrap)
                            state <= ST_RC;
                    end
                    default: state <= ST_RC;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Dividers and clock enables
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            tick_cnt      <= 5'h00;
            act_div       <= `SCS_RST_DIV;
            RADIO_CLK_EN  <= 1'b0;
            PERIPH_CLK_EN <= 1'b0;
            CPU_CLK_EN    <= 1'b0;
            SLOW_CLK_EN   <= 1'b0;
            HS_ON_XTAL    <= 1'b0;
            HS_RC_EN      <= 1'b1;
            HS_XTAL_EN    <= 1'b0;
            SLOW_XTAL_EN  <= 1'b0;
        end else if (CE) begin
            if (hs_tick)
                tick_cnt <= tick_cnt + 5'h01;
            // New divider is taken only at a wrap, keeping every cycle whole
            if (wrap)
                act_div <= cpu_div;
            RADIO_CLK_EN  <= hs_tick;
            PERIPH_CLK_EN <= hs_tick & tick_cnt[0];
            CPU_CLK_EN    <= hs_tick &
                             ((tick_cnt & div_mask(act_div)) == div_mask(act_div));
            SLOW_CLK_EN   <= slow_tick;
            HS_ON_XTAL    <= (state == ST_XTAL);
            HS_RC_EN      <= ~SLEEP & (state != ST_XTAL);
            HS_XTAL_EN    <= ~SLEEP & (hs_mode != `SCS_MODE_STAY_RC);
            SLOW_XTAL_EN  <= (slow_sel == `SCS_SLOW_XTAL);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Slow RC activity monitor
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rc_gap      <= 14'h0000;
            slow_rc_run <= 1'b0;
        end else if (CE) begin
            if (srcx_rise) begin
                rc_gap      <= 14'h0000;
                slow_rc_run <= 1'b1;
            end else if (rc_gap >= SLOW_RC_TIMEOUT[13:0] - 14'h0001) begin
                slow_rc_run <= 1'b0;
            end else begin
                rc_gap <= rc_gap + 14'h0001;
            end
        end
    end

endmodule // scs_clock_control

`default_nettype wire

// File: verif/scs_osc_model.sv
// Oscillators and external slow clock pin seen by the clock control block.
// Assumes the enables come straight from the block's outputs.
`timescale 1ns/1ps
`default_nettype none
module scs_osc_model #(
    parameter int READY_NS = 2000
) (
    input  wire logic hs_rc_en,
    input  wire logic hs_xtal_en,
    input  wire logic slow_xtal_en,
    input  wire logic xtal_fail,
    input  wire logic slow_rc_stop,
    input  wire logic ext_run,
    output logic      hs_rc,
    output logic      hs_xtal,
    output logic      hs_ready,
    output logic      slow_rc,
    output logic      slow_xtal,
    output logic      io_nine
);
    int ready_cnt = 0;
    ////////////////////////////////////////////////////////////
    // Stopped sources sit low; rates stay far below the sampling clock
    always #35 hs_rc = hs_rc_en && (hs_rc !== 1'h1);
    always #31 hs_xtal = hs_xtal_en && (hs_xtal !== 1'h1);
    always #150 slow_rc = !slow_rc_stop && (slow_rc !== 1'h1);
    always #200 slow_xtal = slow_xtal_en && (slow_xtal !== 1'h1);
    always #250 io_nine = ext_run && (io_nine !== 1'h1);
    // Amplitude flag only after a start-up delay, dropped on demand
    always #100 ready_cnt = hs_xtal_en ? ready_cnt + 1 : 0;
    assign hs_ready = (ready_cnt >= READY_NS / 100) && !xtal_fail;
endmodule // scs_osc_model
`default_nettype wire

// File: verif/scs_clock_control_asserts.sv
// Concurrent checks on the ports of the clock control block.
// Assumes it is bound to scs_clock_control.
`timescale 1ns/1ps
`default_nettype none
module scs_clock_control_asserts #(
    parameter SLOW_RC_TIMEOUT = 50
) (
    input wire logic        CLK,
    input wire logic        RESET_N,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic [11:0] PADDR,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        SLEEP,
    input wire logic        HS_XTAL_READY,
    input wire logic        RADIO_CLK_EN,
    input wire logic        PERIPH_CLK_EN,
    input wire logic        CPU_CLK_EN,
    input wire logic        SLOW_XTAL_EN,
    input wire logic        HS_ON_XTAL
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    ////////////////////////////////////////////////////////////
    a_pready_wait: assert property (PSEL && $rose(PENABLE) |-> !PREADY ##1 PREADY ##1 !PREADY)
        else $error("pready not after one wait state");
    a_err_unmapped: assert property (PREADY |-> PSLVERR == (PADDR > 12'h010 || PADDR[1:0] != 2'h0))
        else $error("pslverr does not match address");
    a_xtal_ready: assert property ($rose(HS_ON_XTAL) |-> $past(HS_XTAL_READY, 2))
        else $error("crystal taken without ready flag");
    a_sleep_rc: assert property (SLEEP [*3] |-> !HS_ON_XTAL)
        else $error("crystal kept while asleep");
    a_ticks_sleep: assert property (SLEEP [*3] |-> !RADIO_CLK_EN && !CPU_CLK_EN)
        else $error("fast ticks while asleep");
    a_cpu_tick: assert property (CPU_CLK_EN |-> RADIO_CLK_EN)
        else $error("cpu tick off a fast tick");
    a_periph_half: assert property (PERIPH_CLK_EN |-> RADIO_CLK_EN ##1 !PERIPH_CLK_EN)
        else $error("peripheral tick not halved");
    a_slow_lock: assert property (SLOW_XTAL_EN |=> SLOW_XTAL_EN)
        else $error("slow crystal source dropped");
    c_xtal: cover property ($rose(HS_ON_XTAL));
    c_err: cover property (PREADY && PSLVERR);
    c_slow: cover property ($rose(SLOW_XTAL_EN));
endmodule // scs_clock_control_asserts
bind scs_clock_control scs_clock_control_asserts #(.SLOW_RC_TIMEOUT(SLOW_RC_TIMEOUT))
    scs_clock_control_asserts_inst (.CLK, .RESET_N, .PSEL, .PENABLE, .PADDR, .PREADY, .PSLVERR,
    .SLEEP, .HS_XTAL_READY, .RADIO_CLK_EN, .PERIPH_CLK_EN, .CPU_CLK_EN, .SLOW_XTAL_EN, .HS_ON_XTAL);
`default_nettype wire

// File: verif/test_scs_clock_control.sv
// Self-checking bench for the system clock source control block.
// Assumes the oscillator model stands in for every clock source.
`timescale 1ns/1ps
`default_nettype none
module test_scs_clock_control;
    typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} scs_row_t;
    logic CLK = 1'h0, RESET_N = 1'h0, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0, SLEEP = 1'h0;
    logic xtal_fail = 1'h0, slow_rc_stop = 1'h0, ext_run = 1'h0, er;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0, rd;
    wire logic [31:0] PRDATA;
    wire logic [15:0] SLOW_CAL;
    wire logic [7:0] HS_RC_TRIM;
    wire logic PREADY, PSLVERR, HS_RC_OSC, HS_XTAL_OSC, HS_XTAL_READY, SLOW_RC_OSC, SLOW_XTAL_OSC;
    wire logic GENERAL_IO_NINE, HS_RC_EN, HS_XTAL_EN, SLOW_XTAL_EN, RADIO_CLK_EN, PERIPH_CLK_EN;
    wire logic CPU_CLK_EN, SLOW_CLK_EN, HS_ON_XTAL;
    int failures, num_checks, n_radio, n_periph, n_cpu, n_slow, r, p, c, s;
    scs_row_t rows[12];
    scs_clock_control #(.SLOW_RC_TIMEOUT(50)) scs_clock_control_inst (
        .CLK, .RESET_N, .CE(1'h1), .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
        .PSLVERR, .SLEEP, .HS_RC_OSC, .HS_XTAL_OSC, .HS_XTAL_READY, .SLOW_RC_OSC, .SLOW_XTAL_OSC,
        .GENERAL_IO_NINE, .HS_RC_EN, .HS_XTAL_EN, .HS_RC_TRIM, .SLOW_XTAL_EN, .SLOW_CAL,
        .RADIO_CLK_EN, .PERIPH_CLK_EN, .CPU_CLK_EN, .SLOW_CLK_EN, .HS_ON_XTAL);
    scs_osc_model scs_osc_model_inst (
        .hs_rc_en(HS_RC_EN), .hs_xtal_en(HS_XTAL_EN), .slow_xtal_en(SLOW_XTAL_EN), .xtal_fail,
        .slow_rc_stop, .ext_run, .hs_rc(HS_RC_OSC), .hs_xtal(HS_XTAL_OSC), .hs_ready(HS_XTAL_READY),
        .slow_rc(SLOW_RC_OSC), .slow_xtal(SLOW_XTAL_OSC), .io_nine(GENERAL_IO_NINE));
    always #5 CLK = ~CLK;
    // Free-running tallies; tests take differences, so nothing races a clear
    always @(posedge CLK) begin
        n_radio <= n_radio + (RADIO_CLK_EN === 1'h1);
        n_periph <= n_periph + (PERIPH_CLK_EN === 1'h1);
        n_cpu <= n_cpu + (CPU_CLK_EN === 1'h1);
        n_slow <= n_slow + (SLOW_CLK_EN === 1'h1);
    end
    ////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        n = 0;
        PSEL <= 1'h1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'h1;
        do begin
            @(posedge CLK);
            n++;
        end while (PREADY !== 1'h1 && n < 20);
        q = PRDATA;
        e = PSLVERR;
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
        chk("pready", 1, n < 20);
        if (n >= 20) print_verdict();
        // One idle edge, so back-to-back calls never drive PSEL twice in one step
        @(posedge CLK);
    endtask
    task automatic wait_xtal(input logic v);
        int n;
        n = 0;
        while (HS_ON_XTAL !== v && n < 3000) begin
            @(posedge CLK);
            n++;
        end
        chk("HS_ON_XTAL", v, HS_ON_XTAL);
        if (n >= 3000) print_verdict();
    endtask
    task automatic count(input int cyc, output int rr, output int pp, output int cc, output int ss);
        int r0, p0, c0, s0;
        r0 = n_radio;
        p0 = n_periph;
        c0 = n_cpu;
        s0 = n_slow;
        repeat (cyc) @(posedge CLK);
        rr = n_radio - r0;
        pp = n_periph - p0;
        cc = n_cpu - c0;
        ss = n_slow - s0;
    endtask
    task print_verdict;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        rows = '{'{1'h0, 12'h000, 32'h0, 32'h0, 1'h0}, '{1'h0, 12'h008, 32'h0, 32'h0, 1'h0},
            '{1'h0, 12'h00C, 32'h0, 32'h0, 1'h0}, '{1'h0, 12'h010, 32'h0, 32'h0, 1'h0},
            '{1'h1, 12'h00C, 32'h1A5, 32'h0, 1'h0}, '{1'h0, 12'h00C, 32'h0, 32'hA5, 1'h0},
            '{1'h1, 12'h010, 32'h1BEEF, 32'h0, 1'h0}, '{1'h0, 12'h010, 32'h0, 32'hBEEF, 1'h0},
            '{1'h1, 12'h014, 32'h5, 32'h0, 1'h1}, '{1'h0, 12'h014, 32'h0, 32'h0, 1'h1},
            '{1'h1, 12'h000, 32'h28, 32'h0, 1'h0}, '{1'h0, 12'h000, 32'h0, 32'h28, 1'h0}};
        repeat (12) @(posedge CLK);
        RESET_N <= 1'h1;
        @(posedge CLK);
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d, rd, er);
            chk("prdata", rows[i].q, rd);
            chk("pslverr", rows[i].e, er);
        end
        chk("trim", 32'hA5, HS_RC_TRIM);
        chk("cal", 32'hBEEF, SLOW_CAL);
        // New divider only lands at a tick-counter wrap, up to 32 fast ticks later
        repeat (300) @(posedge CLK);
        count(4000, r, p, c, s);
        chk("cpu_ratio", 1, c > 0 && r + 32 > c * 32 && r < c * 32 + 32);
        chk("periph_ratio", 1, r + 1 >= p * 2 && r <= p * 2 + 1);
        $display("registers and dividers done");
        apb(1'h1, 12'h000, 32'h1, rd, er);
        repeat (20) @(posedge CLK);
        chk("early_xtal", 0, HS_ON_XTAL);
        wait_xtal(1'h1);
        chk("rc_en_off", 0, HS_RC_EN);
        apb(1'h0, 12'h004, 32'h0, rd, er);
        chk("status", 32'h83, rd & 32'hC3);
        xtal_fail <= 1'h1;
        wait_xtal(1'h0);
        xtal_fail <= 1'h0;
        wait_xtal(1'h1);
        SLEEP <= 1'h1;
        repeat (5) @(posedge CLK);
        count(50, r, p, c, s);
        chk("sleep_ticks", 0, r);
        SLEEP <= 1'h0;
        repeat (2) @(posedge CLK);
        chk("wake_rc", 0, HS_ON_XTAL);
        apb(1'h1, 12'h000, 32'h2, rd, er);
        repeat (400) @(posedge CLK);
        chk("sw_wait", 0, HS_ON_XTAL);
        apb(1'h1, 12'h000, 32'h6, rd, er);
        wait_xtal(1'h1);
        apb(1'h0, 12'h00C, 32'h0, rd, er);
        chk("trim_kept", 32'hA5, rd);
        $display("fast source done");
        apb(1'h0, 12'h004, 32'h0, rd, er);
        chk("rc_running", 32'h4, rd & 32'h4);
        slow_rc_stop <= 1'h1;
        ext_run <= 1'h1;
        apb(1'h1, 12'h008, 32'h2, rd, er);
        apb(1'h1, 12'h008, 32'h1, rd, er);
        repeat (200) @(posedge CLK);
        apb(1'h0, 12'h004, 32'h0, rd, er);
        chk("slow_status", 32'h28, rd & 32'h3C);
        chk("rc_stopped", 0, rd & 32'h4);
        chk("xtal_off", 0, SLOW_XTAL_EN);
        count(500, r, p, c, s);
        chk("ext_ticks", 1, s > 0);
        RESET_N <= 1'h0;
        repeat (3) @(posedge CLK);
        RESET_N <= 1'h1;
        @(posedge CLK);
        chk("reset_rc", 0, HS_ON_XTAL);
        apb(1'h0, 12'h008, 32'h0, rd, er);
        chk("slow_default", 0, rd);
        ext_run <= 1'h0;
        apb(1'h1, 12'h008, 32'h1, rd, er);
        count(500, r, p, c, s);
        chk("slow_xtal", 1, SLOW_XTAL_EN === 1'h1 && s > 0);
        $display("slow source done");
        print_verdict();
    end
endmodule // test_scs_clock_control
`default_nettype wire
